// ### design/ptc_ctrl.sv
// How it works
// - one compare-match interrupt enable per timer 0..3, odd bits, reset to off.
// - one underflow interrupt enable per timer 0..3, even bits, reset to off.
// - a second enable register holds the same pairs for timers 4..7.
// - a compare match of a timer sets its compare flag, read 1 means pending.
// - an underflow of a timer sets its underflow flag beside the compare flag.
// - writing 1 clears a flag, writing 0 leaves it, all flags reset to 0.
// - a second flag register holds timers 4..7 with the same behaviour.
// - the mode bit cascades timers 0 and 1 into one 16-bit timer when set.
// - the filter enable puts a noise rejector into the external clock 0 path.
// - each of timers 0 and 1 drives its output clock onto a pin when enabled.
// - the input select bit picks external clock when 1, internal when 0.
// - a per-timer source bit picks the first oscillator when 1, second when 0.
// - a two-bit priority field for the timer 0/1 pair, reset to 0.
// ptc_ctrl: APB slave holding the control, enable and flag registers of the
// programmable timers, plus timers 0 and 1 themselves.
// assumes: every input is synchronous to clk_sys; timers 2..7 report their
// events as one-cycle pulses; reload and compare data come from outside.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ptc_ctrl #(
    parameter int ADDR_W = 18,
    parameter int NR_CYC = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              osc_a_tick,
    input  wire logic              osc_b_tick,
    input  wire logic              ext_clk0,
    input  wire logic              ext_clk1,
    input  wire logic [7:0]        reload_t0,
    input  wire logic [7:0]        reload_t1,
    input  wire logic [7:0]        compare_t0,
    input  wire logic [7:0]        compare_t1,
    input  wire logic [7:2]        cmp_evt_in,
    input  wire logic [7:2]        unf_evt_in,
    output logic                   clk_out_t0,
    output logic                   clk_out_t1,
    output logic [1:0]             prio_t01,
    output logic                   irq
);
    // elaboration-time limits
    if (ADDR_W < 18)
        $error("ADDR_W must reach the register indices");
    if (NR_CYC < 1 || NR_CYC > 15)
        $error("NR_CYC must lie in 1..15");

    ptc_pkg::ptc_state_s s_q;
    ptc_pkg::ptc_state_s s_d;

    logic [7:0]  count_t0;
    logic [7:0]  count_t1;
    logic        unf_t0;
    logic        unf_t1;
    logic        cmp_t0;
    logic        cmp_t1;
    logic        tick_t0;
    logic        tick_t1;
    logic        preset_t0;
    logic        preset_t1;
    logic        ext0_sel;
    logic        ext0_edge;
    logic        ext1_edge;
    logic        timer_zero_int;
    logic        timer_one_int;
    logic [15:0] idx;
    logic        wr_take;
    logic [7:0]  set03;
    logic [7:0]  set47;

    assign idx     = paddr[17:2];
    assign wr_take = psel && penable && s_q.pready && pwrite;

    // internal clock source per timer
    assign timer_zero_int = s_q.osc_sel[0] ? osc_a_tick : osc_b_tick;
    assign timer_one_int  = s_q.osc_sel[1] ? osc_a_tick : osc_b_tick;

    // external clock edges, clock 0 optionally through the rejector
    assign ext0_sel  = s_q.ctl0[ptc_pkg::CTL_FILT_EN];
    assign ext0_edge = ext0_sel ? (s_q.filt_lvl && !s_q.filt_prev)
                                : (ext_clk0 && !s_q.ext0_prev);
    assign ext1_edge = ext_clk1 && !s_q.ext1_prev;

    // count source and 16-bit cascade
    assign tick_t0 = s_q.ctl0[ptc_pkg::CTL_IN_SEL] ? ext0_edge : timer_zero_int;
    assign tick_t1 = s_q.ctl0[ptc_pkg::CTL_MODE16] ? unf_t0
                   : (s_q.ctl1[ptc_pkg::CTL_IN_SEL] ? ext1_edge : timer_one_int);

    // preset strobes, only on a written 1
    assign preset_t0 = wr_take && idx == ptc_pkg::IDX_CTL0
                       && pwdata[ptc_pkg::CTL_PRESET];
    assign preset_t1 = wr_take && idx == ptc_pkg::IDX_CTL1
                       && pwdata[ptc_pkg::CTL_PRESET];

    // flag set vectors, underflow in even bits
    assign set03 = {cmp_evt_in[3], unf_evt_in[3], cmp_evt_in[2], unf_evt_in[2],
                    cmp_t1, unf_t1, cmp_t0, unf_t0};
    assign set47 = {cmp_evt_in[7], unf_evt_in[7], cmp_evt_in[6], unf_evt_in[6],
                    cmp_evt_in[5], unf_evt_in[5], cmp_evt_in[4], unf_evt_in[4]};

    ptc_counter u_timer_zero (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick_t0),
        .run     (s_q.ctl0[ptc_pkg::CTL_RUN]),
        .preset  (preset_t0),
        .reload  (reload_t0),
        .compare (compare_t0),
        .count_q (count_t0),
        .unf_q   (unf_t0),
        .cmp_q   (cmp_t0)
    );

    ptc_counter u_timer_one (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick_t1),
        .run     (s_q.ctl1[ptc_pkg::CTL_RUN]),
        .preset  (preset_t1),
        .reload  (reload_t1),
        .compare (compare_t1),
        .count_q (count_t1),
        .unf_q   (unf_t1),
        .cmp_q   (cmp_t1)
    );

    // next state: bus slave, flags, filter, output clocks, interrupt
    always_comb
    begin
        s_d         = s_q;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.ext0_prev = ext_clk0;
        s_d.ext1_prev = ext_clk1;
        s_d.filt_prev = s_q.filt_lvl;

        // noise rejector: level passes after NR_CYC stable cycles
        if (ext_clk0 == s_q.filt_lvl)
            s_d.filt_cnt = 4'h0;
        else if (s_q.filt_cnt == 4'(NR_CYC - 1))
        begin
            s_d.filt_lvl = ext_clk0;
            s_d.filt_cnt = 4'h0;
        end
        else
            s_d.filt_cnt = s_q.filt_cnt + 4'h1;

        // setup phase: decode and answer in the access phase
        case (s_q.phase)
            ptc_pkg::PTC_IDLE:
            begin
                if (psel && !penable)
                begin
                    s_d.phase  = ptc_pkg::PTC_ACCESS;
                    s_d.pready = 1'b1;
                    s_d.prdata = 32'h0000_0000;
                    case (idx)
                        ptc_pkg::IDX_OSC_SEL: s_d.prdata[1:0] = s_q.osc_sel;
                        ptc_pkg::IDX_PRIO:    s_d.prdata[3:2] = s_q.prio;
                        ptc_pkg::IDX_EN03:    s_d.prdata[7:0] = s_q.en03;
                        ptc_pkg::IDX_FLG03:   s_d.prdata[7:0] = s_q.flg03;
                        ptc_pkg::IDX_EN47:    s_d.prdata[7:0] = s_q.en47;
                        ptc_pkg::IDX_FLG47:   s_d.prdata[7:0] = s_q.flg47;
                        ptc_pkg::IDX_CTL0:    s_d.prdata[7:0] = s_q.ctl0;
                        ptc_pkg::IDX_CTL1:    s_d.prdata[7:0] = s_q.ctl1;
                        default:              s_d.pslverr = 1'b1;
                    endcase
                end
            end
            ptc_pkg::PTC_ACCESS:
            begin
                s_d.phase = ptc_pkg::PTC_IDLE;
            end
            default:
            begin
                s_d.phase = ptc_pkg::PTC_IDLE;
            end
        endcase

        // register writes taken at the access edge
        if (wr_take)
        begin
            case (idx)
                ptc_pkg::IDX_OSC_SEL: s_d.osc_sel = pwdata[1:0];
                ptc_pkg::IDX_PRIO:    s_d.prio = pwdata[3:2];
                ptc_pkg::IDX_EN03:    s_d.en03 = pwdata[7:0];
                ptc_pkg::IDX_EN47:    s_d.en47 = pwdata[7:0];
                ptc_pkg::IDX_CTL0:    s_d.ctl0 = pwdata[7:0] & ptc_pkg::CTL0_MASK;
                ptc_pkg::IDX_CTL1:    s_d.ctl1 = pwdata[7:0] & ptc_pkg::CTL1_MASK;
                default:              s_d.ctl0 = s_q.ctl0;
            endcase
        end

        // write-one-to-clear, a set in the same cycle wins
        s_d.flg03 = s_q.flg03;
        s_d.flg47 = s_q.flg47;
        if (wr_take && idx == ptc_pkg::IDX_FLG03)
            s_d.flg03 = s_q.flg03 & ~pwdata[7:0];
        if (wr_take && idx == ptc_pkg::IDX_FLG47)
            s_d.flg47 = s_q.flg47 & ~pwdata[7:0];
        s_d.flg03 = s_d.flg03 | set03;
        s_d.flg47 = s_d.flg47 | set47;

        // output clocks toggle on underflow, pins gated by the enables
        if (unf_t0)
            s_d.tog[0] = ~s_q.tog[0];
        if (unf_t1)
            s_d.tog[1] = ~s_q.tog[1];
        s_d.clk_out[0] = s_q.tog[0] && s_q.ctl0[ptc_pkg::CTL_CLK_OUT];
        s_d.clk_out[1] = s_q.tog[1] && s_q.ctl1[ptc_pkg::CTL_CLK_OUT];

        // interrupt level from enabled pending flags
        s_d.irq = |(s_q.flg03 & s_q.en03) || |(s_q.flg47 & s_q.en47);
    end

    // state register, all fields clear at reset
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_q         <= '0;
            s_q.phase   <= ptc_pkg::PTC_IDLE;
            s_q.en03    <= ptc_pkg::RST_REG8;
            s_q.en47    <= ptc_pkg::RST_REG8;
            s_q.flg03   <= ptc_pkg::RST_REG8;
            s_q.flg47   <= ptc_pkg::RST_REG8;
            s_q.ctl0    <= ptc_pkg::RST_REG8;
            s_q.ctl1    <= ptc_pkg::RST_REG8;
            s_q.osc_sel <= ptc_pkg::RST_REG2;
            s_q.prio    <= ptc_pkg::RST_REG2;
        end
        else
            s_q <= s_d;
    end

    assign prdata     = s_q.prdata;
    assign pready     = s_q.pready;
    assign pslverr    = s_q.pslverr;
    assign clk_out_t0 = s_q.clk_out[0];
    assign clk_out_t1 = s_q.clk_out[1];
    assign prio_t01   = s_q.prio;
    assign irq        = s_q.irq;

    // checks
    chk_cmp_flag_set : assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmp_t0 |=> s_q.flg03[1])
        else $error("compare flag not set");
    chk_unf_flag_set : assert property (@(posedge clk_sys) disable iff (!rst_n)
        unf_evt_in[7] |=> s_q.flg47[6])
        else $error("underflow flag not set");
    chk_w1c_clear : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_take && idx == ptc_pkg::IDX_FLG03 && pwdata[2] && !unf_t1)
        |=> !s_q.flg03[2])
        else $error("flag not cleared by write one");
    chk_w0_keeps : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_take && idx == ptc_pkg::IDX_FLG03 && !pwdata[5] && s_q.flg03[5])
        |=> s_q.flg03[5])
        else $error("flag lost on write zero");
    chk_irq_level : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_q.flg03[0] && s_q.en03[0]) |=> irq)
        else $error("enabled flag gave no interrupt");
    chk_preset_reads0 : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pready && !pslverr && !pwrite && idx == ptc_pkg::IDX_CTL1)
        |-> !prdata[ptc_pkg::CTL_PRESET])
        else $error("preset bit read as one");
    chk_cascade : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_q.ctl0[ptc_pkg::CTL_MODE16] && !unf_t0 && !preset_t1)
        |=> $stable(count_t1))
        else $error("timer one moved without a timer zero underflow");
    chk_clk_out_off : assert property (@(posedge clk_sys) disable iff (!rst_n)
        !s_q.ctl0[ptc_pkg::CTL_CLK_OUT] |=> !clk_out_t0)
        else $error("clock output while disabled");
    chk_ext_select : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!s_q.ctl0[ptc_pkg::CTL_IN_SEL] && !timer_zero_int && !preset_t0)
        |=> $stable(count_t0))
        else $error("timer zero moved without an internal tick");
    chk_setup_ready : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (psel && !penable && s_q.phase == ptc_pkg::PTC_IDLE) |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    cov_cmp_irq   : cover property (@(posedge clk_sys) disable iff (!rst_n) cmp_t0 ##2 irq);
    cov_mode16    : cover property (@(posedge clk_sys) disable iff (!rst_n)
        s_q.ctl0[ptc_pkg::CTL_MODE16] && unf_t1);
    cov_filtered  : cover property (@(posedge clk_sys) disable iff (!rst_n) ext0_sel && ext0_edge);
    cov_unmapped  : cover property (@(posedge clk_sys) disable iff (!rst_n) pready && pslverr);
endmodule : ptc_ctrl
`default_nettype wire

// ### design/ptc_pkg.sv
// ptc_pkg: register indices, field positions, reset values and state types
// for the programmable timer control block.
// assumes: nothing beyond a SystemVerilog compiler.
package ptc_pkg;
    // register indices; the APB byte address is four times the index
    localparam logic [15:0] IDX_OSC_SEL  = 16'hFF1A;
    localparam logic [15:0] IDX_PRIO     = 16'hFF21;
    localparam logic [15:0] IDX_EN03     = 16'hFF25;
    localparam logic [15:0] IDX_FLG03    = 16'hFF29;
    localparam logic [15:0] IDX_EN47     = 16'hFF2C;
    localparam logic [15:0] IDX_FLG47    = 16'hFF2E;
    localparam logic [15:0] IDX_CTL0     = 16'hFF30;
    localparam logic [15:0] IDX_CTL1     = 16'hFF31;

    // control register fields
    localparam int CTL_MODE16    = 7;
    localparam int CTL_FILT_EN   = 6;
    localparam int CTL_RSVD      = 4;
    localparam int CTL_CLK_OUT   = 3;
    localparam int CTL_RUN       = 2;
    localparam int CTL_PRESET    = 1;
    localparam int CTL_IN_SEL    = 0;
    localparam logic [7:0] CTL0_MASK = 8'hDD;
    localparam logic [7:0] CTL1_MASK = 8'h1D;

    // priority field: bit 3 high, bit 2 low
    localparam int PRIO_LO       = 2;

    // reset values
    localparam logic [7:0] RST_REG8  = 8'h00;
    localparam logic [1:0] RST_REG2  = 2'h0;

    // counter state
    typedef struct packed {
        logic [7:0] count;
        logic       unf;
        logic       cmp;
    } ptc_cnt_s;

    // apb phase of the slave
    typedef enum logic [0:0] {PTC_IDLE, PTC_ACCESS} ptc_phase_e;

    // whole state of the control block
    typedef struct packed {
        ptc_phase_e phase;
        logic [7:0] en03;
        logic [7:0] en47;
        logic [7:0] flg03;
        logic [7:0] flg47;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [1:0] osc_sel;
        logic [1:0] prio;
        logic [31:0] prdata;
        logic       pready;
        logic       pslverr;
        logic       filt_lvl;
        logic       filt_prev;
        logic [3:0] filt_cnt;
        logic       ext0_prev;
        logic       ext1_prev;
        logic [1:0] tog;
        logic [1:0] clk_out;
        logic       irq;
    } ptc_state_s;
endpackage : ptc_pkg

// ### design/ptc_counter.sv
// ptc_counter: one 8-bit down counter with reload, compare and underflow.
// assumes: tick is a one-cycle enable in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module ptc_counter (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       preset,
    input  wire logic [7:0] reload,
    input  wire logic [7:0] compare,
    output logic      [7:0] count_q,
    output logic            unf_q,
    output logic            cmp_q
);
    ptc_pkg::ptc_cnt_s s_q;
    ptc_pkg::ptc_cnt_s s_d;

    // count down on tick while running, reload on underflow or preset
    always_comb
    begin
        s_d     = s_q;
        s_d.unf = 1'b0;
        s_d.cmp = 1'b0;
        if (preset)
        begin
            s_d.count = reload;
        end
        else if (tick && run)
        begin
            if (s_q.count == 8'h00)
            begin
                s_d.count = reload;
                s_d.unf   = 1'b1;
            end
            else
            begin
                s_d.count = s_q.count - 8'h01;
            end
            s_d.cmp = (s_q.count == compare);
        end
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign count_q = s_q.count;
    assign unf_q   = s_q.unf;
    assign cmp_q   = s_q.cmp;

    // a stopped counter holds its value unless preset
    chk_stop_holds : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!run && !preset) |=> $stable(count_q))
        else $error("counter moved while stopped");
endmodule : ptc_counter
`default_nettype wire

// ### tb/ptc_apb_master.sv
// ptc_apb_master: processor side of the register bus, one transfer per req pulse.
// assumes: req is raised for one cycle while done is low and no transfer runs.
`timescale 1ns/1ps
`default_nettype none
module ptc_apb_master (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        req,
    input  wire logic        wr,
    input  wire logic [17:0] addr,
    input  wire logic [31:0] wdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [17:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic      [31:0] rdata,
    output logic             err,
    output logic             done
);
    // setup, access until pready, then release with scrambled write data
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= 18'h00000;
            pwdata  <= 32'h00000000;
            rdata   <= 32'h00000000;
            err     <= 1'b0;
            done    <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (psel && penable && pready)
            begin
                rdata   <= prdata;
                err     <= pslverr;
                done    <= 1'b1;
                psel    <= 1'b0;
                penable <= 1'b0;
                pwdata  <= ~pwdata; // released data no longer valid
            end
            else if (psel)
                penable <= 1'b1;
            else if (req)
            begin
                psel   <= 1'b1;
                pwrite <= wr;
                paddr  <= addr;
                pwdata <= wdata;
            end
        end
    end
endmodule : ptc_apb_master
`default_nettype wire

// ### tb/tb_programmable_timer_control.sv
// tb_programmable_timer_control: register table, flags, interrupt and timer 0/1 checks.
// assumes: ptc_ctrl answers each bus transfer with one access cycle.
`timescale 1ns/1ps
`default_nettype none
module tb_programmable_timer_control;
    typedef struct {logic [15:0] idx; logic [7:0] wd; logic [7:0] rd;} ptc_row_s;
    logic        clk_sys, rst_n, req, wr, done, err, psel, penable, pwrite, pready, pslverr;
    logic [17:0] addr, paddr;
    logic [31:0] wdata, rdata, pwdata, prdata, rv;
    logic        osc_a_tick, osc_b_tick, ext_clk0, ext_clk1, clk_out_t0, clk_out_t1, irq, ev;
    logic [7:0]  reload_t0, reload_t1, compare_t0, compare_t1;
    logic [7:2]  cmp_evt_in, unf_evt_in;
    logic [1:0]  prio_t01;
    int          n_fail, cmp_count;
    ptc_row_s    rows [6];
    logic [15:0] all_idx [8];

    ptc_apb_master u_mst (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .wr(wr), .addr(addr),
        .wdata(wdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rdata(rdata), .err(err), .done(done));
    ptc_ctrl #(.ADDR_W(18), .NR_CYC(4)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_a_tick(osc_a_tick), .osc_b_tick(osc_b_tick),
        .ext_clk0(ext_clk0), .ext_clk1(ext_clk1), .reload_t0(reload_t0), .reload_t1(reload_t1),
        .compare_t0(compare_t0), .compare_t1(compare_t1), .cmp_evt_in(cmp_evt_in),
        .unf_evt_in(unf_evt_in), .clk_out_t0(clk_out_t0), .clk_out_t1(clk_out_t1),
        .prio_t01(prio_t01), .irq(irq));

    // 200 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // one bus transfer, waits for done under a bound
    task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk_sys);
        req <= 1'b1;
        wr <= w;
        addr <= {idx, 2'b00};
        wdata <= wd;
        @(posedge clk_sys);
        req <= 1'b0;
        do
        begin
            @(posedge clk_sys);
            #1;
            k++;
        end while (done !== 1'b1 && k < 50);
        if (k >= 50)
            n_fail++;
        rv = rdata;
        ev = err;
    endtask : bus

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 32'h00000000);
        check(rv, {24'h000000, exp});
    endtask : rd_chk

    // n one-cycle ticks on the first (a=1) or second oscillator
    task automatic tk(input logic a, input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            osc_a_tick <= a;
            osc_b_tick <= !a;
            @(posedge clk_sys);
            osc_a_tick <= 1'b0;
            osc_b_tick <= 1'b0;
        end
    endtask : tk

    task automatic evt(input logic [7:2] c, input logic [7:2] u);
        @(posedge clk_sys);
        cmp_evt_in <= c;
        unf_evt_in <= u;
        @(posedge clk_sys);
        cmp_evt_in <= 6'h00;
        unf_evt_in <= 6'h00;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : evt

    // cut a hung run short
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end

    initial
    begin
        {rst_n, req, wr, osc_a_tick, osc_b_tick, ext_clk0, ext_clk1} = 7'h00;
        {addr, wdata, cmp_evt_in, unf_evt_in} = '0;
        {reload_t0, compare_t0, reload_t1, compare_t1} = {8'h03, 8'h01, 8'h00, 8'h80};
        n_fail = 0;
        cmp_count = 0;
        all_idx = '{ptc_pkg::IDX_OSC_SEL, ptc_pkg::IDX_PRIO, ptc_pkg::IDX_EN03,
            ptc_pkg::IDX_FLG03, ptc_pkg::IDX_EN47, ptc_pkg::IDX_FLG47, ptc_pkg::IDX_CTL0,
            ptc_pkg::IDX_CTL1};
        rows = '{'{ptc_pkg::IDX_EN03, 8'hFF, 8'hFF}, '{ptc_pkg::IDX_EN47, 8'hA5, 8'hA5},
            '{ptc_pkg::IDX_CTL0, 8'hFF, 8'hDD}, '{ptc_pkg::IDX_CTL1, 8'hFF, 8'h1D},
            '{ptc_pkg::IDX_OSC_SEL, 8'h03, 8'h03}, '{ptc_pkg::IDX_PRIO, 8'h0C, 8'h0C}};
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values of every register and of irq, clk_out_t0 and prio_t01
        foreach (all_idx[i])
            rd_chk(all_idx[i], 8'h00);
        check({28'h0, irq, clk_out_t0, prio_t01}, 32'h0);
        // table rows: write then read back
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].idx, {24'hFFFFFF, rows[i].wd});
            rd_chk(rows[i].idx, rows[i].rd);
        end
        check({30'h0, prio_t01}, 32'h3);
        // unmapped index is refused
        bus(1'b0, 16'h0001, 32'h0);
        check({31'h0, ev}, 32'h1);
        // timer 2 compare event sets its flag, irq follows the enable
        evt(6'h01, 6'h00);
        rd_chk(ptc_pkg::IDX_FLG03, 8'h20);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, ptc_pkg::IDX_FLG03, 32'h0);
        rd_chk(ptc_pkg::IDX_FLG03, 8'h20);
        bus(1'b1, ptc_pkg::IDX_FLG03, 32'h20);
        rd_chk(ptc_pkg::IDX_FLG03, 8'h00);
        // timer 7 underflow while masked, then unmasked, then cleared
        evt(6'h00, 6'h20);
        rd_chk(ptc_pkg::IDX_FLG47, 8'h40);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, ptc_pkg::IDX_EN47, 32'h40);
        @(posedge clk_sys);
        #1;
        check({31'h0, irq}, 32'h1);
        bus(1'b1, ptc_pkg::IDX_FLG47, 32'h40);
        rd_chk(ptc_pkg::IDX_FLG47, 8'h00);
        check({31'h0, irq}, 32'h0);
        // timer 0: preset to 3, first oscillator only, compare then underflow
        bus(1'b1, ptc_pkg::IDX_OSC_SEL, 32'h01);
        bus(1'b1, ptc_pkg::IDX_CTL0, 32'h0E);
        tk(1'b0, 4);
        rd_chk(ptc_pkg::IDX_FLG03, 8'h00);
        tk(1'b1, 3);
        rd_chk(ptc_pkg::IDX_FLG03, 8'h02);
        tk(1'b1, 1);
        rd_chk(ptc_pkg::IDX_FLG03, 8'h03);
        check({31'h0, clk_out_t0}, 32'h1);
        // stopped timer ignores ticks
        bus(1'b1, ptc_pkg::IDX_FLG03, 32'h03);
        bus(1'b1, ptc_pkg::IDX_CTL0, 32'h08);
        tk(1'b1, 4);
        rd_chk(ptc_pkg::IDX_FLG03, 8'h00);
        // timer 1 on its external clock underflows on one rising edge
        bus(1'b1, ptc_pkg::IDX_CTL1, 32'h05);
        @(posedge clk_sys);
        ext_clk1 <= 1'b1;
        repeat (3) @(posedge clk_sys);
        ext_clk1 <= 1'b0;
        rd_chk(ptc_pkg::IDX_FLG03, 8'h04);
        // timer 1 output clock shows its toggle once enabled
        bus(1'b1, ptc_pkg::IDX_CTL1, 32'h0D);
        @(posedge clk_sys);
        #1;
        check({31'h0, clk_out_t1}, 32'h1);
        // timer 0 on external clock 0 through the rejector, reload 0
        @(posedge clk_sys);
        reload_t0 <= 8'h00;
        bus(1'b1, ptc_pkg::IDX_CTL0, 32'h47);
        @(posedge clk_sys);
        ext_clk0 <= 1'b1;
        repeat (2) @(posedge clk_sys);
        ext_clk0 <= 1'b0;
        rd_chk(ptc_pkg::IDX_FLG03, 8'h04);
        @(posedge clk_sys);
        ext_clk0 <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ext_clk0 <= 1'b0;
        rd_chk(ptc_pkg::IDX_FLG03, 8'h05);
        bus(1'b1, ptc_pkg::IDX_FLG03, 32'h05);
        rd_chk(ptc_pkg::IDX_FLG03, 8'h00);
        // reset in mid-run returns registers and outputs to zero
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(ptc_pkg::IDX_CTL0, 8'h00);
        rd_chk(ptc_pkg::IDX_EN03, 8'h00);
        check({28'h0, irq, clk_out_t1, prio_t01}, 32'h0);
        close_out();
    end
endmodule : tb_programmable_timer_control
`default_nettype wire
